// ===== verilog/cpu_irq_iface_defs.svh
`ifndef CPU_IRQ_IFACE_DEFS_SVH
`define CPU_IRQ_IFACE_DEFS_SVH

// System-register encodings {op0, op1, crn, crm, op2} packed into 16 bits.
`define SEL_AP0_0 16'hc644
`define SEL_AP0_1 16'hc645
`define SEL_AP0_2 16'hc646
`define SEL_AP0_3 16'hc647
`define SEL_AP1_0 16'hc648
`define SEL_AP1_1 16'hc649
`define SEL_AP1_2 16'hc64a
`define SEL_AP1_3 16'hc64b
`define SEL_BPR0 16'hc643
`define SEL_BPR1 16'hc663
`define SEL_CTLR1 16'hc664
`define SEL_CTLR3 16'hf664

// Field positions.
`define SDU_BIT 17
`define A3V_BIT 15
`define LOCAL_SYSTEM_ERROR_IRQ_SUPPORT_BIT 14
`define IDB_LSB 11
`define PRIB_LSB 8
`define PRIO_MASK_HINT_ENABLE_BIT 6
`define RM_BIT 5
`define EOI_NS_BIT 4
`define EOI_S_BIT 3
`define EOI_L3_BIT 2
`define COMMON_SPLIT_SELECT_NS_BIT 1
`define COMMON_SPLIT_SELECT_S_BIT 0
`define CTL1_EOI_BIT 1
`define CTL1_COMMON_SPLIT_SELECT_BIT 0

// Constant field values and reset values.
`define IRQ_IDENTIFIER_WIDTH_VAL 3'h0
`define PRIORITY_WIDTH_VAL 3'h4
`define BPR0_MIN 3'h2
`define BPR1_S_MIN 3'h2
`define BPR1_NS_MIN 3'h3
`define AP_RESET 32'h00000000
`define BPR0_RESET 3'h2
`define BPR1_S_RESET 3'h2
`define BPR1_NS_RESET 3'h3

`endif

// ===== verilog/cpu_irq_iface_pkg.sv
package cpu_irq_iface_pkg;

    typedef enum logic [1:0] {
        LVL_NS_L1,
        LVL_S_L1,
        LVL_L3
    } exc_level_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] sel;
        exc_level_type level;
        logic [31:0] wdata;
    } sysreg_req_type;

    typedef struct packed {
        logic valid;
        logic undef;
        logic [31:0] rdata;
    } sysreg_rsp_type;

    typedef struct packed {
        logic prio_mask_hint_enable;
        logic end_of_irq_mode;
        logic common_split_select;
        logic [2:0] group0_split;
        logic [2:0] group1_split;
    } cfg_view_type;

endpackage

// ===== verilog/cpu_irq_interface_priority_ctrl.sv
`timescale 1ns/100ps
`include "cpu_irq_iface_defs.svh"
// What this block does
// - Holds a 32-bit group 0 active-priority register, one bit per level.
// - Holds a separate 32-bit group 1 active-priority register.
// - Five priority bits; bit n stands for priority n times eight.
// - Both active-priority registers reset to zero.
// - Group 0 split field is three bits dividing priority for preemption.
// - Group 0 split field never holds a value below two.
// - Group 1 split minimum is two secure, three non-secure.
// - Level 1 view reads affinity-level-3-valid as one.
// - Local system-error-interrupt support reads as zero.
// - Identifier-width reads zero; level 1 mirrors level 3.
// - Priority-width field reads four.
// - Active-priority registers one to three of either group are undefined.
// - Mask hint enable is read-only at level 1, mirrors level 3.
// - End-of-irq mode picks drop-and-deactivate or drop only.
// - Common-split makes group 0 split govern both groups.
// - Security-disable-unsupported reads one and ignores writes.
// - Level 3 affinity-level-3-valid reads one, writes ignored.
// - Level 3 routing-modifier reads zero, writes ignored.
// - Level 3 holds three end-of-irq mode bits: non-secure, secure and level 3.
// - Level 3 holds two common-split bits, one per security state.
// - Level 3 mask hint enable is writable.
// - Registers reachable only through the system-register port.
module cpu_irq_interface_priority_ctrl
    import cpu_irq_iface_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // System-register access port
    input wire sysreg_req_type req_i,
    output sysreg_rsp_type rsp_o,
    // Active view of preemption settings for the current level
    input wire exc_level_type cur_level_i,
    output cfg_view_type cfg_o,
    // Active priorities toward the distributor side
    output logic [31:0] group0_active_o,
    output logic [31:0] group1_active_o,
    // Decoded effects of end-of-interrupt and deactivate writes
    output logic eoi_deactivates_o,
    output logic deactivate_unpredictable_o
);

    logic [31:0] group0_active_priorities;
    logic [31:0] group1_active_priorities;
    logic [2:0] group0_priority_split;
    logic [2:0] group1_split_secure;
    logic [2:0] group1_split_nonsecure;
    logic prio_mask_hint_enable;
    logic end_of_irq_mode_nonsecure_l1;
    logic end_of_irq_mode_secure_l1;
    logic end_of_irq_mode_l3;
    logic common_split_nonsecure_l1;
    logic common_split_secure_l1;

    logic wr;
    logic is_secure;
    logic sel_eoi;
    logic sel_common_split_select;
    logic [2:0] wr_split;
    logic [2:0] g1_min;
    logic [31:0] ctl1_word;
    logic [31:0] ctl3_word;
    logic [31:0] next_rdata;
    logic next_undef;
    logic next_hit;
    logic [2:0] next_g1_split;
    logic next_eoi;
    logic next_common_split_select;

    assign wr = req_i.valid & req_i.write;
    assign is_secure = (req_i.level != LVL_NS_L1);
    assign wr_split = req_i.wdata[2:0];
    assign g1_min = is_secure ? `BPR1_S_MIN : `BPR1_NS_MIN;

    // The level 1 view selects the bank of the requesting security state; level 3 reads its own end-of-irq bit.
    always_comb begin
        case (req_i.level)
            LVL_NS_L1: begin
                sel_eoi = end_of_irq_mode_nonsecure_l1;
                sel_common_split_select = common_split_nonsecure_l1;
            end
            LVL_S_L1: begin
                sel_eoi = end_of_irq_mode_secure_l1;
                sel_common_split_select = common_split_secure_l1;
            end
            LVL_L3: begin
                sel_eoi = end_of_irq_mode_l3;
                sel_common_split_select = common_split_secure_l1;
            end
            default: begin
                sel_eoi = 1'b0;
                sel_common_split_select = 1'b0;
            end
        endcase
    end

    always_comb begin
        ctl1_word = 32'h00000000;
        ctl1_word[`A3V_BIT] = 1'b1;
        ctl1_word[`LOCAL_SYSTEM_ERROR_IRQ_SUPPORT_BIT] = 1'b0;
        ctl1_word[`IDB_LSB +: 3] = `IRQ_IDENTIFIER_WIDTH_VAL;
        ctl1_word[`PRIB_LSB +: 3] = `PRIORITY_WIDTH_VAL;
        ctl1_word[`PRIO_MASK_HINT_ENABLE_BIT] = prio_mask_hint_enable;
        ctl1_word[`CTL1_EOI_BIT] = sel_eoi;
        ctl1_word[`CTL1_COMMON_SPLIT_SELECT_BIT] = sel_common_split_select;
    end

    always_comb begin
        ctl3_word = 32'h00000000;
        ctl3_word[`SDU_BIT] = 1'b1;
        ctl3_word[`A3V_BIT] = 1'b1;
        ctl3_word[`LOCAL_SYSTEM_ERROR_IRQ_SUPPORT_BIT] = 1'b0;
        ctl3_word[`IDB_LSB +: 3] = `IRQ_IDENTIFIER_WIDTH_VAL;
        ctl3_word[`PRIB_LSB +: 3] = `PRIORITY_WIDTH_VAL;
        ctl3_word[`PRIO_MASK_HINT_ENABLE_BIT] = prio_mask_hint_enable;
        ctl3_word[`RM_BIT] = 1'b0;
        ctl3_word[`EOI_NS_BIT] = end_of_irq_mode_nonsecure_l1;
        ctl3_word[`EOI_S_BIT] = end_of_irq_mode_secure_l1;
        ctl3_word[`EOI_L3_BIT] = end_of_irq_mode_l3;
        ctl3_word[`COMMON_SPLIT_SELECT_NS_BIT] = common_split_nonsecure_l1;
        ctl3_word[`COMMON_SPLIT_SELECT_S_BIT] = common_split_secure_l1;
    end

    // Read decode; only the system-register port reaches these.
    always_comb begin
        next_rdata = 32'h00000000;
        next_undef = 1'b0;
        next_hit = 1'b1;
        case (req_i.sel)
            `SEL_AP0_0: next_rdata = group0_active_priorities;
            `SEL_AP1_0: next_rdata = group1_active_priorities;
            `SEL_AP0_1, `SEL_AP0_2, `SEL_AP0_3,
            `SEL_AP1_1, `SEL_AP1_2, `SEL_AP1_3: begin
                next_undef = 1'b1;
                next_hit = 1'b0;
            end
            `SEL_BPR0: next_rdata = {29'h0, group0_priority_split};
            `SEL_BPR1: next_rdata = is_secure ?
                {29'h0, group1_split_secure} :
                {29'h0, group1_split_nonsecure};
            `SEL_CTLR1: next_rdata = ctl1_word;
            `SEL_CTLR3: begin
                if (req_i.level == LVL_L3) begin
                    next_rdata = ctl3_word;
                end else begin
                    next_undef = 1'b1;
                    next_hit = 1'b0;
                end
            end
            default: begin
                next_undef = 1'b1;
                next_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rsp_o <= '0;
        end else begin
            rsp_o.valid <= req_i.valid;
            rsp_o.undef <= req_i.valid & next_undef;
            rsp_o.rdata <= (req_i.valid & ~req_i.write) ?
                next_rdata : 32'h00000000;
        end
    end

    // Active-priority storage, one bit per level of eight.
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            group0_active_priorities <= `AP_RESET;
            group1_active_priorities <= `AP_RESET;
        end else if (wr) begin
            if (req_i.sel == `SEL_AP0_0) begin
                group0_active_priorities <= req_i.wdata;
            end
            if (req_i.sel == `SEL_AP1_0) begin
                group1_active_priorities <= req_i.wdata;
            end
        end
    end

    // Split fields clamp below their minimum.
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            group0_priority_split <= `BPR0_RESET;
        end else if (wr && req_i.sel == `SEL_BPR0) begin
            group0_priority_split <= (wr_split < `BPR0_MIN) ?
                `BPR0_MIN : wr_split;
        end
    end

    assign next_g1_split = (wr_split < g1_min) ? g1_min : wr_split;

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            group1_split_secure <= `BPR1_S_RESET;
            group1_split_nonsecure <= `BPR1_NS_RESET;
        end else if (wr && req_i.sel == `SEL_BPR1) begin
            if (is_secure) begin
                group1_split_secure <= next_g1_split;
            end else begin
                group1_split_nonsecure <= next_g1_split;
            end
        end
    end

    // Control bits: level 3 writes all; level 1 writes its own bank only.
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prio_mask_hint_enable <= 1'b0;
            end_of_irq_mode_nonsecure_l1 <= 1'b0;
            end_of_irq_mode_secure_l1 <= 1'b0;
            end_of_irq_mode_l3 <= 1'b0;
            common_split_nonsecure_l1 <= 1'b0;
            common_split_secure_l1 <= 1'b0;
        end else if (wr && req_i.sel == `SEL_CTLR3 &&
                     req_i.level == LVL_L3) begin
            prio_mask_hint_enable <= req_i.wdata[`PRIO_MASK_HINT_ENABLE_BIT];
            end_of_irq_mode_nonsecure_l1 <= req_i.wdata[`EOI_NS_BIT];
            end_of_irq_mode_secure_l1 <= req_i.wdata[`EOI_S_BIT];
            end_of_irq_mode_l3 <= req_i.wdata[`EOI_L3_BIT];
            common_split_nonsecure_l1 <= req_i.wdata[`COMMON_SPLIT_SELECT_NS_BIT];
            common_split_secure_l1 <= req_i.wdata[`COMMON_SPLIT_SELECT_S_BIT];
        end else if (wr && req_i.sel == `SEL_CTLR1) begin
            case (req_i.level)
                LVL_NS_L1: begin
                    end_of_irq_mode_nonsecure_l1 <=
                        req_i.wdata[`CTL1_EOI_BIT];
                    common_split_nonsecure_l1 <= req_i.wdata[`CTL1_COMMON_SPLIT_SELECT_BIT];
                end
                LVL_S_L1: begin
                    end_of_irq_mode_secure_l1 <= req_i.wdata[`CTL1_EOI_BIT];
                    common_split_secure_l1 <= req_i.wdata[`CTL1_COMMON_SPLIT_SELECT_BIT];
                end
                LVL_L3: begin
                    end_of_irq_mode_l3 <= req_i.wdata[`CTL1_EOI_BIT];
                    common_split_secure_l1 <= req_i.wdata[`CTL1_COMMON_SPLIT_SELECT_BIT];
                end
                default: begin
                    end_of_irq_mode_l3 <= end_of_irq_mode_l3;
                end
            endcase
        end
    end

    // Effective configuration for the level currently executing.
    always_comb begin
        case (cur_level_i)
            LVL_NS_L1: begin
                next_eoi = end_of_irq_mode_nonsecure_l1;
                next_common_split_select = common_split_nonsecure_l1;
            end
            LVL_S_L1: begin
                next_eoi = end_of_irq_mode_secure_l1;
                next_common_split_select = common_split_secure_l1;
            end
            LVL_L3: begin
                next_eoi = end_of_irq_mode_l3;
                next_common_split_select = common_split_secure_l1;
            end
            default: begin
                next_eoi = 1'b0;
                next_common_split_select = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cfg_o <= '0;
            eoi_deactivates_o <= 1'b0;
            deactivate_unpredictable_o <= 1'b0;
            group0_active_o <= 32'h00000000;
            group1_active_o <= 32'h00000000;
        end else begin
            cfg_o.prio_mask_hint_enable <= prio_mask_hint_enable;
            cfg_o.end_of_irq_mode <= next_eoi;
            cfg_o.common_split_select <= next_common_split_select;
            cfg_o.group0_split <= group0_priority_split;
            if (next_common_split_select) begin
                cfg_o.group1_split <= group0_priority_split;
            end else if (cur_level_i == LVL_NS_L1) begin
                cfg_o.group1_split <= group1_split_nonsecure;
            end else begin
                cfg_o.group1_split <= group1_split_secure;
            end
            eoi_deactivates_o <= ~next_eoi;
            deactivate_unpredictable_o <= ~next_eoi;
            group0_active_o <= group0_active_priorities;
            group1_active_o <= group1_active_priorities;
        end
    end

endmodule

// ===== test/cpu_irq_iface_checker.sv
`timescale 1ns/100ps
`include "cpu_irq_iface_defs.svh"
module cpu_irq_iface_checker
    import cpu_irq_iface_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // Watched ports
    input wire sysreg_req_type req_i,
    input wire sysreg_rsp_type rsp_o,
    input wire exc_level_type cur_level_i,
    input wire cfg_view_type cfg_o,
    input wire logic [31:0] group0_active_o,
    input wire logic [31:0] group1_active_o,
    input wire logic eoi_deactivates_o,
    input wire logic deactivate_unpredictable_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    logic rd_c1;
    logic rd_c3;
    logic ap_hi;
    assign rd_c1 = req_i.valid && !req_i.write && req_i.sel == `SEL_CTLR1;
    assign rd_c3 = req_i.valid && !req_i.write && req_i.sel == `SEL_CTLR3;
    assign ap_hi = req_i.valid && (req_i.sel inside {`SEL_AP0_1, `SEL_AP0_2,
        `SEL_AP0_3, `SEL_AP1_1, `SEL_AP1_2, `SEL_AP1_3});

    property p_answer;
        req_i.valid |=> rsp_o.valid && !$past(rsp_o.valid);
    endproperty
    a_answer: assert property (p_answer)
        else $error("access not answered after one cycle");
    property p_ap_undef;
        ap_hi |=> rsp_o.undef && rsp_o.rdata == 32'h0;
    endproperty
    a_ap_undef: assert property (p_ap_undef)
        else $error("upper active-priority access not refused");
    property p_ap0_write;
        req_i.valid && req_i.write && req_i.sel == `SEL_AP0_0
            |=> ##1 group0_active_o == $past(req_i.wdata, 2);
    endproperty
    a_ap0_write: assert property (p_ap0_write)
        else $error("group 0 active priorities not updated");
    property p_ap1_write;
        req_i.valid && req_i.write && req_i.sel == `SEL_AP1_0
            |=> ##1 group1_active_o == $past(req_i.wdata, 2);
    endproperty
    a_ap1_write: assert property (p_ap1_write)
        else $error("group 1 active priorities not updated");
    property p_split_min;
        !$past(sys_rst_i) |-> cfg_o.group0_split >= 3'h2
            && cfg_o.group1_split >= 3'h2;
    endproperty
    a_split_min: assert property (p_split_min)
        else $error("split field below its minimum");
    property p_ctl3_fixed;
        rd_c3 && req_i.level == LVL_L3
            |=> !rsp_o.undef && (rsp_o.rdata & 32'hffffffa0) == 32'h00028400;
    endproperty
    a_ctl3_fixed: assert property (p_ctl3_fixed)
        else $error("level 3 control fixed bits wrong");
    property p_ctl1_fixed;
        rd_c1 |=> (rsp_o.rdata & 32'hffffffbc) == 32'h00008400;
    endproperty
    a_ctl1_fixed: assert property (p_ctl1_fixed)
        else $error("level 1 control fixed bits wrong");
    property p_eoi;
        !$past(sys_rst_i) |-> eoi_deactivates_o == !cfg_o.end_of_irq_mode
            && deactivate_unpredictable_o == eoi_deactivates_o;
    endproperty
    a_eoi: assert property (p_eoi)
        else $error("end-of-irq decode disagrees with mode");
    property p_common;
        cfg_o.common_split_select |-> cfg_o.group1_split == cfg_o.group0_split;
    endproperty
    a_common: assert property (p_common)
        else $error("common split not applied to group 1");
endmodule

bind cpu_irq_interface_priority_ctrl cpu_irq_iface_checker i_chk (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
    .rsp_o(rsp_o), .cur_level_i(cur_level_i), .cfg_o(cfg_o),
    .group0_active_o(group0_active_o), .group1_active_o(group1_active_o),
    .eoi_deactivates_o(eoi_deactivates_o),
    .deactivate_unpredictable_o(deactivate_unpredictable_o));

// ===== test/sysreg_core_model.sv
`timescale 1ns/100ps
module sysreg_core_model
    import cpu_irq_iface_pkg::*;
(
    // Clock
    input wire logic core_clk_i,
    // Access port toward the interface
    input wire sysreg_rsp_type rsp_i,
    output sysreg_req_type req_o
);
    initial req_o = '0;

    // One access: launched after a falling edge, answer taken a cycle later.
    task automatic access(input logic w, input logic [15:0] sel,
        input exc_level_type lvl, input logic [31:0] wd,
        output sysreg_rsp_type rsp);
        @(negedge core_clk_i);
        req_o = '{1'b1, w, sel, lvl, wd};
        @(posedge core_clk_i);
        @(negedge core_clk_i);
        rsp = rsp_i;
        req_o.valid = 1'b0;
        req_o.wdata = ~wd;
    endtask
endmodule

// ===== test/tb_cpu_irq_interface_priority_ctrl.sv
`timescale 1ns/100ps
`include "cpu_irq_iface_defs.svh"
module tb_cpu_irq_interface_priority_ctrl
    import cpu_irq_iface_pkg::*;
;
    logic core_clk_i;
    logic sys_rst_i;
    sysreg_req_type req;
    sysreg_rsp_type rsp;
    sysreg_rsp_type got;
    exc_level_type cur_level;
    cfg_view_type cfg;
    logic [31:0] g0;
    logic [31:0] g1;
    logic eoi_deact;
    logic deact_unp;
    int num_errors = 0;
    int total_checks = 0;

    cpu_irq_interface_priority_ctrl i_dut (.core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i), .req_i(req), .rsp_o(rsp),
        .cur_level_i(cur_level), .cfg_o(cfg), .group0_active_o(g0),
        .group1_active_o(g1), .eoi_deactivates_o(eoi_deact),
        .deactivate_unpredictable_o(deact_unp));
    sysreg_core_model i_core (.core_clk_i(core_clk_i), .rsp_i(rsp),
        .req_o(req));

    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic wr(logic [15:0] s, exc_level_type l, logic [31:0] d);
        i_core.access(1'b1, s, l, d, got);
        repeat (2) @(negedge core_clk_i);
    endtask

    task automatic rd(logic [15:0] s, exc_level_type l, logic [31:0] exp,
        string what);
        i_core.access(1'b0, s, l, 32'h0, got);
        check(what, got.rdata, exp);
    endtask

    task automatic t_reset();
        rd(`SEL_AP0_0, LVL_NS_L1, 32'h0, "ap0");
        rd(`SEL_AP1_0, LVL_NS_L1, 32'h0, "ap1");
        rd(`SEL_BPR0, LVL_NS_L1, 32'h2, "bpr0");
        rd(`SEL_BPR1, LVL_NS_L1, 32'h3, "bpr1ns");
        rd(`SEL_BPR1, LVL_S_L1, 32'h2, "bpr1s");
        rd(`SEL_CTLR3, LVL_L3, 32'h00028400, "ctl3");
        rd(`SEL_CTLR1, LVL_NS_L1, 32'h00008400, "ctl1");
        $display("test reset done");
    endtask

    task automatic t_active();
        logic [15:0] hi[6] = '{`SEL_AP0_1, `SEL_AP0_2, `SEL_AP0_3,
            `SEL_AP1_1, `SEL_AP1_2, `SEL_AP1_3};
        wr(`SEL_AP0_0, LVL_NS_L1, 32'h80000001);
        wr(`SEL_AP1_0, LVL_S_L1, 32'h00000002);
        rd(`SEL_AP0_0, LVL_NS_L1, 32'h80000001, "ap0");
        rd(`SEL_AP1_0, LVL_S_L1, 32'h00000002, "ap1");
        check("g0out", g0, 32'h80000001);
        check("g1out", g1, 32'h00000002);
        foreach (hi[i]) begin
            i_core.access(1'b1, hi[i], LVL_L3, 32'hffffffff, got);
            check("undef", {31'h0, got.undef}, 32'h1);
        end
        rd(`SEL_AP0_0, LVL_NS_L1, 32'h80000001, "ap0keep");
        $display("test active done");
    endtask

    task automatic t_split();
        wr(`SEL_BPR0, LVL_NS_L1, 32'h1);
        rd(`SEL_BPR0, LVL_NS_L1, 32'h2, "bpr0min");
        wr(`SEL_BPR0, LVL_NS_L1, 32'hfffffff5);
        rd(`SEL_BPR0, LVL_NS_L1, 32'h5, "bpr0res");
        wr(`SEL_BPR1, LVL_NS_L1, 32'h2);
        rd(`SEL_BPR1, LVL_NS_L1, 32'h3, "bpr1nsmin");
        cur_level = LVL_S_L1;
        wr(`SEL_BPR1, LVL_S_L1, 32'h6);
        check("cfg_g0", {29'h0, cfg.group0_split}, 32'h5);
        check("cfg_g1", {29'h0, cfg.group1_split}, 32'h6);
        $display("test split done");
    endtask

    task automatic t_ctl();
        wr(`SEL_CTLR3, LVL_L3, 32'hffffffff);
        rd(`SEL_CTLR3, LVL_L3, 32'h0002845f, "ctl3all");
        rd(`SEL_CTLR1, LVL_NS_L1, 32'h00008443, "ctl1ns");
        wr(`SEL_CTLR1, LVL_NS_L1, 32'h0);
        rd(`SEL_CTLR3, LVL_L3, 32'h0002844d, "ctl3ns0");
        check("prio_mask_hint_enable", {31'h0, cfg.prio_mask_hint_enable}, 32'h1);
        check("eoi_s1", {31'h0, eoi_deact}, 32'h0);
        check("g1_common", {29'h0, cfg.group1_split}, 32'h5);
        wr(`SEL_CTLR1, LVL_S_L1, 32'h0);
        check("eoi_s0", {31'h0, eoi_deact}, 32'h1);
        check("unp_s0", {31'h0, deact_unp}, 32'h1);
        check("g1_own", {29'h0, cfg.group1_split}, 32'h6);
        $display("test control done");
    endtask

    task automatic t_misc();
        i_core.access(1'b0, `SEL_CTLR3, LVL_NS_L1, 32'h0, got);
        check("c3ns_valid", {31'h0, got.valid}, 32'h1);
        check("c3ns_undef", {31'h0, got.undef}, 32'h1);
        check("c3ns_rdata", got.rdata, 32'h0);
        cur_level = LVL_L3;
        wr(`SEL_CTLR3, LVL_L3, 32'h00000004);
        check("l3_eoi", {31'h0, cfg.end_of_irq_mode}, 32'h1);
        check("l3_deact", {31'h0, eoi_deact}, 32'h0);
        check("l3_common_split_select", {31'h0, cfg.common_split_select}, 32'h0);
        check("l3_g1", {29'h0, cfg.group1_split}, 32'h6);
        check("l3_prio_mask_hint_enable", {31'h0, cfg.prio_mask_hint_enable}, 32'h0);
        @(negedge core_clk_i);
        sys_rst_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        rd(`SEL_AP0_0, LVL_NS_L1, 32'h0, "ap0rst");
        rd(`SEL_CTLR3, LVL_L3, 32'h00028400, "ctl3rst");
        check("g0rst", g0, 32'h0);
        $display("test misc done");
    endtask

    initial begin
        sys_rst_i = 1'b1;
        cur_level = LVL_NS_L1;
        repeat (2) @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        t_reset();
        t_active();
        t_split();
        t_ctl();
        t_misc();
        give_verdict();
    end

    initial begin
        #20000;
        num_errors++;
        give_verdict();
    end
endmodule
